// [common/timer16_defines.svh]
// Purpose: address map, fields, reset values of the 16-bit timer
// Assumes: 8-bit register data, 4-bit register address
// Notes: definitions only
`ifndef TIMER16_DEFINES_SVH
`define TIMER16_DEFINES_SVH

// ****************************************
// register addresses
// ****************************************
`define TMR_ADDR_W 4
`define TMR_ADR_CTRL_ONE 4'h0
`define TMR_ADR_CTRL_TWO 4'h1
`define TMR_ADR_STATUS 4'h2
`define TMR_ADR_CNT_HI 4'h3
`define TMR_ADR_CNT_LO 4'h4
`define TMR_ADR_ALT_HI 4'h5
`define TMR_ADR_ALT_LO 4'h6
`define TMR_ADR_EVT_STAT 4'h7
`define TMR_ADR_EVT_MASK 4'h8

// ****************************************
// fields
// ****************************************
`define TMR_BIT_OVF_IE 0
`define TMR_BIT_CS_LO 0
`define TMR_BIT_CS_HI 1
`define TMR_BIT_EDGE 2
`define TMR_BIT_OVF 0
`define TMR_BIT_EVT_OVF 0

// ****************************************
// values
// ****************************************
`define TMR_RELOAD 16'hfffc
`define TMR_TOP 16'hffff
`define TMR_CS_DIV4 2'h0
`define TMR_CS_DIV2 2'h1
`define TMR_CS_DIV8 2'h2
`define TMR_CS_EXT 2'h3
`define TMR_PRE_DIV2 3'h1
`define TMR_PRE_DIV4 3'h3
`define TMR_PRE_DIV8 3'h7
`define TMR_BYTE_ZERO 8'h00

`endif

// [common/timer16_pkg.sv]
// Purpose: types shared by the 16-bit timer files
// Assumes: timer16_defines.svh holds the numbers
// Notes: none
`default_nettype none
`include "timer16_defines.svh"
package timer16_pkg;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [`TMR_ADDR_W-1:0] addr;
		logic [7:0] wdata;
	} reg_req_s;

	typedef enum logic [1:0] {
		RS_LIVE = 2'b01,
		RS_HELD = 2'b10
	} rd_state_e;
endpackage
`default_nettype wire

// [sim/cpu_bus_model.sv]
// Purpose: cpu side of the timer register port
// Assumes: one-cycle strobes, read data in the cycle after the read
// Notes: released address and data show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"
module cpu_bus_model (
	// clock
	input wire logic i_clk,
	// register port
	input wire logic [7:0] i_rdata,
	output var timer16_pkg::reg_req_s o_req
);
	import timer16_pkg::*;
	initial o_req = '0;
	task automatic wr(input logic [`TMR_ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge i_clk);
		o_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
		#1;
	endtask
	task automatic rd(input logic [`TMR_ADDR_W-1:0] a, output logic [7:0] d);
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge i_clk);
		o_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hff};
		#1;
		d = i_rdata;
	endtask
endmodule // cpu_bus_model
`default_nettype wire

// [sim/timer16_free_running_counter_tb.sv]
// Purpose: self-checking bench of the 16-bit timer counter
// Assumes: model mirrors prescaler phase from reset
// Notes: count compared every cycle until the external clock tests
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"
module timer16_free_running_counter_tb;
	import timer16_pkg::*;
	logic i_clk, i_reset_n, i_halt, i_int_mask, i_ext_clk, i_ext_bonded, irq, chk_en;
	reg_req_s req;
	logic [7:0] rdata, lat;
	logic [15:0] count, mcnt;
	logic [2:0] mpre;
	logic [1:0] mcs;
	int errors, total_checks, seed, n;

	timer16_counter #(.COUNT_W(16)) uut (.i_clk(i_clk), .i_reset_n(i_reset_n),
		.i_req(req), .o_rdata(rdata), .i_halt(i_halt), .i_int_mask(i_int_mask),
		.i_ext_clk(i_ext_clk), .i_ext_bonded(i_ext_bonded), .o_count(count), .o_irq(irq));
	cpu_bus_model cpu (.i_clk(i_clk), .i_rdata(rdata), .o_req(req));

	initial begin
		i_clk = 1'b0;
		forever #5 i_clk = ~i_clk;
	end

	// ****************************************
	// reference model
	// ****************************************
	function automatic logic [2:0] msk(input logic [1:0] cs);
		case (cs)
			`TMR_CS_DIV2: msk = `TMR_PRE_DIV2;
			`TMR_CS_DIV8: msk = `TMR_PRE_DIV8;
			default: msk = `TMR_PRE_DIV4;
		endcase
	endfunction
	always @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			mcnt = `TMR_RELOAD;
			mpre = 3'h0;
			mcs = `TMR_CS_DIV4;
		end else begin
			if (!i_halt) begin
				if (mcs != `TMR_CS_EXT && (mpre & msk(mcs)) == msk(mcs))
					mcnt = mcnt + 16'h0001;
				mpre = mpre + 3'h1;
			end
			if (req.wr && (req.addr == `TMR_ADR_CNT_LO || req.addr == `TMR_ADR_ALT_LO))
				mcnt = `TMR_RELOAD;
			if (req.wr && req.addr == `TMR_ADR_CTRL_TWO)
				mcs = req.wdata[1:0];
		end
	end
	always @(negedge i_clk) if (i_reset_n && chk_en) chk("count", mcnt, count);

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		total_checks++;
		if (g !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd_chk(input logic [`TMR_ADDR_W-1:0] a, input logic [7:0] e);
		logic [7:0] d;
		cpu.rd(a, d);
		chk("rdata", {8'h00, e}, {8'h00, d});
	endtask
	task automatic hold(input logic h);
		@(posedge i_clk) i_halt <= h;
		repeat (2) @(posedge i_clk);
	endtask
	task automatic pulses(input int k);
		repeat (k) begin
			@(posedge i_clk) i_ext_clk <= 1'b1;
			repeat (3) @(posedge i_clk);
			i_ext_clk <= 1'b0;
			repeat (3) @(posedge i_clk);
		end
		repeat (6) @(posedge i_clk);
		#1;
	endtask
	task automatic close_out;
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	initial begin
		#200000;
		errors++;
		close_out;
	end

	initial begin
		seed = 32'hb6d8d782;
		{i_reset_n, i_ext_clk, i_int_mask} = 3'b001;
		{i_halt, i_ext_bonded, chk_en} = 3'b111;
		repeat (6) @(posedge i_clk);
		i_reset_n <= 1'b1;
		rd_chk(`TMR_ADR_CNT_HI, 8'hff);
		rd_chk(`TMR_ADR_ALT_LO, 8'hfc);
		$display("test reset done");
		hold(1'b0);
		for (n = 0; n < 3; n++) begin
			cpu.wr(`TMR_ADR_CTRL_TWO, 8'(n));
			repeat (20 + ($random(seed) & 63)) @(posedge i_clk);
		end
		hold(1'b1);
		repeat (12) @(posedge i_clk);
		hold(1'b0);
		$display("test prescale done");
		cpu.wr(`TMR_ADR_CNT_HI, 8'($random(seed)));
		cpu.wr(`TMR_ADR_CNT_LO, 8'($random(seed)));
		chk("count", `TMR_RELOAD, count);
		repeat (9) @(posedge i_clk);
		cpu.wr(`TMR_ADR_ALT_LO, 8'($random(seed)));
		chk("count", `TMR_RELOAD, count);
		$display("test reload done");
		cpu.wr(`TMR_ADR_CTRL_TWO, {6'h0, `TMR_CS_DIV2});
		hold(1'b1);
		rd_chk(`TMR_ADR_CNT_HI, mcnt[15:8]);
		lat = mcnt[7:0];
		hold(1'b0);
		repeat (17) @(posedge i_clk);
		hold(1'b1);
		rd_chk(`TMR_ADR_ALT_HI, mcnt[15:8]);
		rd_chk(`TMR_ADR_CNT_LO, lat);
		rd_chk(`TMR_ADR_ALT_LO, mcnt[7:0]);
		$display("test latch done");
		hold(1'b0);
		cpu.wr(`TMR_ADR_CTRL_ONE, 8'h01);
		cpu.wr(`TMR_ADR_CNT_LO, 8'h00);
		repeat (12) @(posedge i_clk);
		hold(1'b1);
		chk("irq", 16'h0, {15'h0, irq});
		@(posedge i_clk) i_int_mask <= 1'b0;
		#1 chk("irq", 16'h1, {15'h0, irq});
		rd_chk(`TMR_ADR_CNT_LO, mcnt[7:0]);
		rd_chk(`TMR_ADR_STATUS, 8'h01);
		rd_chk(`TMR_ADR_ALT_LO, mcnt[7:0]);
		rd_chk(`TMR_ADR_STATUS, 8'h01);
		rd_chk(`TMR_ADR_CNT_LO, mcnt[7:0]);
		rd_chk(`TMR_ADR_STATUS, 8'h00);
		chk("irq", 16'h0, {15'h0, irq});
		rd_chk(`TMR_ADR_EVT_STAT, 8'h01);
		cpu.wr(`TMR_ADR_EVT_MASK, 8'h01);
		chk("irq", 16'h1, {15'h0, irq});
		cpu.wr(`TMR_ADR_EVT_STAT, 8'h01);
		chk("irq", 16'h0, {15'h0, irq});
		rd_chk(4'hf, 8'h00);
		$display("test overflow done");
		chk_en <= 1'b0;
		hold(1'b0);
		for (n = 0; n < 2; n++) begin
			cpu.wr(`TMR_ADR_CTRL_TWO, {5'h0, n[0], `TMR_CS_EXT});
			cpu.wr(`TMR_ADR_CNT_LO, 8'h00);
			pulses(5);
			chk("count", 16'h0001, count);
		end
		@(posedge i_clk) i_ext_bonded <= 1'b0;
		repeat (4) @(posedge i_clk);
		cpu.wr(`TMR_ADR_CNT_LO, 8'h00);
		pulses(3);
		chk("count", `TMR_RELOAD, count);
		$display("test external done");
		cpu.wr(`TMR_ADR_CTRL_TWO, {6'h0, `TMR_CS_DIV2});
		repeat (9) @(posedge i_clk);
		@(posedge i_clk) i_reset_n <= 1'b0;
		#1 chk("count", `TMR_RELOAD, count);
		chk("irq", 16'h0, {15'h0, irq});
		@(posedge i_clk) i_reset_n <= 1'b1;
		rd_chk(`TMR_ADR_CTRL_TWO, 8'h00);
		$display("test reset again done");
		close_out;
	end
endmodule // timer16_free_running_counter_tb
`default_nettype wire

// [verilog/ext_clock_edge.sv]
// Purpose: synchronise the external clock pin and pulse on its active edge
// Assumes: pin is asynchronous to i_clk
// Notes: unbonded pin reads as one
`timescale 1ns/1ps
`default_nettype none
module ext_clock_edge (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// pin
	input wire logic i_pin,
	input wire logic i_bonded,
	input wire logic i_falling,
	// count enable
	output logic o_pulse
);
	logic pin_in;
	logic sync1_r;
	logic sync2_r;
	logic prev_r;

	assign pin_in = i_bonded ? i_pin : 1'b1; // R16

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			sync1_r <= 1'b1;
			sync2_r <= 1'b1;
			prev_r <= 1'b1;
		end else begin
			sync1_r <= pin_in; // R17
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// one pulse per selected transition
	assign o_pulse = i_falling ? (prev_r & ~sync2_r) : (~prev_r & sync2_r); // R13
endmodule // ext_clock_edge
`default_nettype wire

// [verilog/timer16_counter.sv]
// Purpose: free-running 16-bit up-counter with latched byte reads
// Assumes: register port, read data one cycle after the read strobe
// Notes: wait mode has no input; the counter simply keeps running
//
// Functional notes
// [R1] 16-bit up-counter clocked by CPU clock /2, /4, /8 or external pin.
// [R2] Clock select code 11 picks the external clock, others the prescaler.
// [R3] Writing either low byte view reloads the counter to FFFCh.
// [R4] Counter resets to FFFCh; that is the only reload value.
// [R5] Both views read-only, same count; alternate low read keeps overflow flag.
// [R6] High byte read latches low byte until the low byte is read.
// [R7] Low byte read without pending high read returns live low byte.
// [R8] Overflow flag sets on FFFFh to 0000h rollover.
// [R9] Interrupt only with enable set and CPU mask clear; else pending. The code also raises it from event status with the event mask set.
// [R10] Flag clears after status read while set, then main low access.
// [R11] Counter keeps running in wait mode.
// [R12] Halt freezes the count; reset restarts from the reset value.
// [R13] Edge select bit picks the active external clock transition.
// [R14] Counter steps in line with the CPU clock, external mode too.
// [R15] External clock needs four CPU clocks between active edges.
// [R16] Unbonded timer input pin reads as one.
// [R17] External pin is synchronised and edge-detected into count pulses.
//
// The implementer's own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "timer16_defines.svh"
module timer16_counter #(
	parameter int COUNT_W = 16
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_reset_n,
	// register port
	input wire timer16_pkg::reg_req_s i_req,
	output logic [7:0] o_rdata,
	// system
	input wire logic i_halt,
	input wire logic i_int_mask,
	// external clock pin
	input wire logic i_ext_clk,
	input wire logic i_ext_bonded,
	// results
	output logic [COUNT_W-1:0] o_count,
	output logic o_irq
);
	import timer16_pkg::*;

	// ****************************************
	// elaboration check
	// ****************************************
	if (COUNT_W != 16) begin : g_bad_width
		$error("timer16_counter supports only a 16-bit count");
	end

	// ****************************************
	// decode
	// ****************************************
	function automatic logic hit(input reg_req_s r, input logic [`TMR_ADDR_W-1:0] a);
		hit = r.addr == a;
	endfunction

	logic rd_main_lo;
	logic rd_alt_lo;
	logic rd_hi;
	logic wr_lo;
	logic main_lo_access;
	logic rd_status;

	assign rd_main_lo = i_req.rd & hit(i_req, `TMR_ADR_CNT_LO);
	assign rd_alt_lo = i_req.rd & hit(i_req, `TMR_ADR_ALT_LO);
	assign rd_hi = i_req.rd & (hit(i_req, `TMR_ADR_CNT_HI) | hit(i_req, `TMR_ADR_ALT_HI));
	assign wr_lo = i_req.wr & (hit(i_req, `TMR_ADR_CNT_LO) | hit(i_req, `TMR_ADR_ALT_LO));
	assign main_lo_access = (i_req.rd | i_req.wr) & hit(i_req, `TMR_ADR_CNT_LO);
	assign rd_status = i_req.rd & hit(i_req, `TMR_ADR_STATUS);

	// ****************************************
	// control registers
	// ****************************************
	logic ovf_irq_enable_r;
	logic [1:0] clock_select_r;
	logic ext_edge_select_r;
	logic evt_stat_r;
	logic evt_mask_r;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			ovf_irq_enable_r <= 1'b0;
		end else if (i_req.wr && hit(i_req, `TMR_ADR_CTRL_ONE)) begin
			ovf_irq_enable_r <= i_req.wdata[`TMR_BIT_OVF_IE];
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clock_select_r <= `TMR_CS_DIV4;
			ext_edge_select_r <= 1'b0;
		end else if (i_req.wr && hit(i_req, `TMR_ADR_CTRL_TWO)) begin
			clock_select_r <= i_req.wdata[`TMR_BIT_CS_HI:`TMR_BIT_CS_LO];
			ext_edge_select_r <= i_req.wdata[`TMR_BIT_EDGE];
		end
	end

	// ****************************************
	// count enable
	// ****************************************
	logic [2:0] presc_r;
	logic ext_pulse;
	logic tick;
	logic ovf_event;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			presc_r <= 3'h0;
		end else if (!i_halt) begin
			presc_r <= presc_r + 3'h1;
		end
	end

	ext_clock_edge u_ext_edge (
		.i_clk(i_clk),
		.i_reset_n(i_reset_n),
		.i_pin(i_ext_clk),
		.i_bonded(i_ext_bonded),
		.i_falling(ext_edge_select_r),
		.o_pulse(ext_pulse)
	);

	// prescaler taps; wait mode does not gate anything
	always_comb begin
		case (clock_select_r) // R2
			`TMR_CS_DIV2: tick = (presc_r & `TMR_PRE_DIV2) == `TMR_PRE_DIV2; // R1
			`TMR_CS_DIV4: tick = (presc_r & `TMR_PRE_DIV4) == `TMR_PRE_DIV4;
			`TMR_CS_DIV8: tick = presc_r == `TMR_PRE_DIV8;
			`TMR_CS_EXT: tick = ext_pulse; // R14
			default: tick = 1'b0;
		endcase
		tick = tick & ~i_halt; // R11 R12
	end

	// ****************************************
	// counter
	// ****************************************
	logic [COUNT_W-1:0] count_r;

	assign ovf_event = tick && !wr_lo && count_r == `TMR_TOP;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			count_r <= `TMR_RELOAD; // R4
		end else if (wr_lo) begin
			count_r <= `TMR_RELOAD; // R3
		end else if (tick) begin
			count_r <= count_r + 16'h0001; // R1
		end
	end

	assign o_count = count_r;

	// ****************************************
	// latched low byte
	// ****************************************
	rd_state_e rd_state_r;
	logic [7:0] low_buf_r;
	logic rd_lo;

	assign rd_lo = rd_main_lo | rd_alt_lo;
	logic [7:0] count_lo;
	assign count_lo = count_r[7:0];

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rd_state_r <= RS_LIVE;
			low_buf_r <= `TMR_BYTE_ZERO;
		end else begin
			case (rd_state_r)
				RS_LIVE: begin
					if (rd_hi) begin
						rd_state_r <= RS_HELD;
						low_buf_r <= count_r[7:0]; // R6
					end
				end
				RS_HELD: begin
					if (rd_lo) begin
						rd_state_r <= RS_LIVE;
					end
				end
				default: rd_state_r <= RS_LIVE;
			endcase
		end
	end

	// ****************************************
	// overflow flag and two-step clear
	// ****************************************
	logic overflow_flag_r;
	logic clr_armed_r;

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			overflow_flag_r <= 1'b0;
		end else if (ovf_event) begin
			overflow_flag_r <= 1'b1; // R8
		end else if (clr_armed_r && main_lo_access) begin
			overflow_flag_r <= 1'b0; // R10
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			clr_armed_r <= 1'b0;
		end else if (rd_status && overflow_flag_r) begin
			clr_armed_r <= 1'b1; // R10
		end else if (!overflow_flag_r || main_lo_access) begin
			clr_armed_r <= 1'b0;
		end
	end

	// ****************************************
	// event status and mask
	// ****************************************
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			evt_stat_r <= 1'b0;
		end else if (ovf_event) begin
			evt_stat_r <= 1'b1;
		end else if (i_req.wr && hit(i_req, `TMR_ADR_EVT_STAT)
			&& i_req.wdata[`TMR_BIT_EVT_OVF]) begin
			evt_stat_r <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			evt_mask_r <= 1'b0;
		end else if (i_req.wr && hit(i_req, `TMR_ADR_EVT_MASK)) begin
			evt_mask_r <= i_req.wdata[`TMR_BIT_EVT_OVF];
		end
	end

	// pending flag raises the line as soon as the mask drops
	assign o_irq = ~i_int_mask
		& ((overflow_flag_r & ovf_irq_enable_r) | (evt_stat_r & evt_mask_r)); // R9

	// ****************************************
	// read data
	// ****************************************
	logic [7:0] rdata_nxt;

	always_comb begin
		rdata_nxt = `TMR_BYTE_ZERO;
		case (i_req.addr)
			`TMR_ADR_CTRL_ONE: rdata_nxt[`TMR_BIT_OVF_IE] = ovf_irq_enable_r;
			`TMR_ADR_CTRL_TWO: begin
				rdata_nxt[`TMR_BIT_CS_HI:`TMR_BIT_CS_LO] = clock_select_r;
				rdata_nxt[`TMR_BIT_EDGE] = ext_edge_select_r;
			end
			`TMR_ADR_STATUS: rdata_nxt[`TMR_BIT_OVF] = overflow_flag_r;
			`TMR_ADR_CNT_HI, `TMR_ADR_ALT_HI: rdata_nxt = count_r[15:8]; // R5
			`TMR_ADR_CNT_LO, `TMR_ADR_ALT_LO: begin
				if (rd_state_r == RS_HELD) begin
					rdata_nxt = low_buf_r; // R6
				end else begin
					rdata_nxt = count_r[7:0]; // R7
				end
			end
			`TMR_ADR_EVT_STAT: rdata_nxt[`TMR_BIT_EVT_OVF] = evt_stat_r;
			`TMR_ADR_EVT_MASK: rdata_nxt[`TMR_BIT_EVT_OVF] = evt_mask_r;
			default: rdata_nxt = `TMR_BYTE_ZERO;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			o_rdata <= `TMR_BYTE_ZERO;
		end else if (i_req.rd) begin
			o_rdata <= rdata_nxt;
		end else begin
			o_rdata <= `TMR_BYTE_ZERO;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	sequence seq_arm;
		rd_status && overflow_flag_r;
	endsequence

	sequence seq_main_low;
		main_lo_access && !ovf_event && !rd_status;
	endsequence

	chk_low_write_reload: assert property (wr_lo |=> count_r == `TMR_RELOAD) // R3
		else $error("low byte write did not reload counter");

	chk_halt_freeze: assert property (i_halt && !wr_lo |=> $stable(count_r)) // R12
		else $error("counter moved during halt");

	chk_rollover_flag: assert property (ovf_event |=> overflow_flag_r && count_r == 16'h0000) // R8
		else $error("rollover did not set overflow flag");

	chk_irq_gating: assert property (ovf_event && ovf_irq_enable_r // R9
		|=> overflow_flag_r && (o_irq || i_int_mask))
		else $error("enabled overflow did not raise interrupt");

	chk_latch_hold: assert property (rd_state_r == RS_HELD && !rd_lo // R6
		|=> $stable(low_buf_r) && rd_state_r == RS_HELD)
		else $error("latched low byte changed");

	chk_live_low: assert property (rd_lo && rd_state_r == RS_LIVE // R7
		|=> o_rdata == $past(count_lo))
		else $error("live low read returned wrong byte");

	chk_hi_latch: assert property (rd_hi && rd_state_r == RS_LIVE // R6
		|=> rd_state_r == RS_HELD && low_buf_r == $past(count_lo))
		else $error("high byte read did not latch low byte");

	chk_two_step: assert property (seq_arm ##1 (!main_lo_access)[*1] ##1 seq_main_low // R10
		|=> !overflow_flag_r)
		else $error("two-step clear failed");

	chk_alt_keeps: assert property (overflow_flag_r && rd_alt_lo |=> overflow_flag_r) // R5
		else $error("alternate low read cleared flag");

	chk_event_sticky: assert property (ovf_event |=> evt_stat_r) // R8
		else $error("rollover did not set event status");

	chk_count_step: assert property (tick && !wr_lo // R1
		|=> count_r == $past(count_r) + 16'h0001)
		else $error("count did not advance on tick");

	chk_ext_step: assert property (clock_select_r == `TMR_CS_EXT && ext_pulse && !i_halt // R2
		&& !wr_lo |=> count_r == $past(count_r) + 16'h0001)
		else $error("external edge did not advance counter");

	chk_div2_rate: assert property (clock_select_r == `TMR_CS_DIV2 && tick // R1
		&& $stable(clock_select_r) |=> !tick)
		else $error("divide-by-two ticked twice in a row");
endmodule // timer16_counter
`default_nettype wire
